// >>> rtl/lbr_recorder.sv
// Last branch recorder: debug control register, four record registers,
// branch stepping, breakpoint pin reporting and branch trace messages.
// Assumes event inputs are one-cycle strobes from the core pipeline,
// all synchronous to i_sys_clk, and offsets already code-segment based.

`timescale 1ns/100ps

module lbr_recorder
  import lbr_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_reset_n,
  // Privileged register read and write
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [LBR_IDX_W-1:0]  i_reg_idx,
  input  wire logic [LBR_DATA_W-1:0] i_reg_wdata,
  input  wire logic [1:0]            i_priv_level,
  input  wire logic                  i_real_mode,
  output logic [LBR_DATA_W-1:0]      o_reg_rdata,
  output logic                       o_reg_ack,
  output logic                       o_reg_fault,
  // Control transfer events, offsets within the code segment
  input  wire logic                  i_branch_taken,
  input  wire logic [LBR_DATA_W-1:0] i_branch_src,
  input  wire logic [LBR_DATA_W-1:0] i_branch_tgt,
  input  wire logic                  i_exc_taken,
  input  wire logic [LBR_DATA_W-1:0] i_exc_src,
  input  wire logic [LBR_DATA_W-1:0] i_exc_tgt,
  input  wire logic                  i_debug_exception,
  // Single stepping
  input  wire logic                  i_single_step_flag,
  input  wire logic                  i_insn_retire,
  output logic                       o_step_trap,
  // Breakpoint and performance reporting
  input  wire logic [LBR_PINS-1:0]   i_bp_match,
  input  wire logic [LBR_PINS-1:0]   i_perf_event,
  output logic [LBR_PINS-1:0]        o_breakpoint_pin_n,
  // Branch trace messages
  output logic                       o_msg_valid,
  output logic [LBR_DATA_W-1:0]      o_msg_src,
  output logic [LBR_DATA_W-1:0]      o_msg_tgt,
  // Control state seen by the core
  output logic                       o_record_enable,
  output logic                       o_step_on_branches
);

  logic [LBR_CTRL_W-1:0]  ctrl_ff;
  logic [LBR_CTRL_W-1:0]  nxt_ctrl;
  logic [LBR_DATA_W-1:0]  br_src_ff;
  logic [LBR_DATA_W-1:0]  br_tgt_ff;
  logic [LBR_DATA_W-1:0]  ex_src_ff;
  logic [LBR_DATA_W-1:0]  ex_tgt_ff;
  logic [LBR_DATA_W-1:0]  rdata_ff;
  logic [LBR_DATA_W-1:0]  nxt_rdata;
  logic                   ack_ff;
  logic                   fault_ff;
  logic [LBR_PINS-1:0]    pin_n_ff;
  logic [LBR_PINS-1:0]    nxt_pin_n;
  logic                   msg_valid_ff;
  logic [LBR_DATA_W-1:0]  msg_src_ff;
  logic [LBR_DATA_W-1:0]  msg_tgt_ff;

  // Control field views
  wire logic                record_enable = ctrl_ff[LBR_BIT_REC];
  wire logic                step_branches = ctrl_ff[LBR_BIT_STEP];
  wire logic [LBR_PINS-1:0] pin_select    =
    ctrl_ff[LBR_BIT_PIN_HI:LBR_BIT_PIN_LO];
  wire logic                msg_enable    = ctrl_ff[LBR_BIT_MSG];

  // Write privilege check; a refused write is flagged, never stored
  wire logic priv_ok  = (i_priv_level == LBR_PRIV_TOP) | i_real_mode;
  wire logic ctrl_sel = (i_reg_idx == LBR_IDX_CTRL);
  wire logic ctrl_wr  = i_reg_wr & ctrl_sel & priv_ok;
  wire logic wr_fault = i_reg_wr & ctrl_sel & ~priv_ok;

  // Recording qualifiers; a debug exception suppresses any capture
  wire logic rec_ok   = record_enable & ~i_debug_exception;
  wire logic rec_exc  = rec_ok & i_exc_taken;
  wire logic rec_br   = rec_ok & i_branch_taken & ~i_exc_taken;

  // Debug exception clear wins over a same-cycle software set, so the
  // handler always starts with recording off
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (ctrl_wr) begin
      nxt_ctrl = i_reg_wdata[LBR_CTRL_W-1:0];
    end
    if (i_debug_exception) begin
      nxt_ctrl[LBR_BIT_REC] = 1'b0;
    end
  end

  // Control register
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      ctrl_ff <= LBR_CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Branch records; exception path loads its own addresses
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      br_src_ff <= LBR_REC_RST;
      br_tgt_ff <= LBR_REC_RST;
    end else if (rec_exc) begin
      br_src_ff <= i_exc_src;
      br_tgt_ff <= i_exc_tgt;
    end else if (rec_br) begin
      br_src_ff <= i_branch_src;
      br_tgt_ff <= i_branch_tgt;
    end
  end

  // Exception records take the old branch pair before it is replaced
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      ex_src_ff <= LBR_REC_RST;
      ex_tgt_ff <= LBR_REC_RST;
    end else if (rec_exc) begin
      ex_src_ff <= br_src_ff;
      ex_tgt_ff <= br_tgt_ff;
    end
  end

  // Read mux; unmapped indices and reserved control bits read zero
  always_comb begin
    nxt_rdata = '0;
    case (i_reg_idx)
      LBR_IDX_CTRL:   nxt_rdata[LBR_CTRL_W-1:0] = ctrl_ff;
      LBR_IDX_BR_SRC: nxt_rdata = br_src_ff;
      LBR_IDX_BR_TGT: nxt_rdata = br_tgt_ff;
      LBR_IDX_EX_SRC: nxt_rdata = ex_src_ff;
      LBR_IDX_EX_TGT: nxt_rdata = ex_tgt_ff;
      default:        nxt_rdata = '0;
    endcase
  end

  // Register access answer, one cycle after the request
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      rdata_ff <= LBR_REC_RST;
      ack_ff   <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      rdata_ff <= i_reg_rd ? nxt_rdata : rdata_ff;
      ack_ff   <= i_reg_rd | i_reg_wr;
      fault_ff <= wr_fault;
    end
  end

  // Pin drive per channel: breakpoint pulse or performance event
  genvar g;
  generate
    for (g = 0; g < LBR_PINS; g++) begin : g_pin
      // Guard on the current level so a held match still pulses
      assign nxt_pin_n[g] = pin_select[g] ?
        ~(i_bp_match[g] & pin_n_ff[g]) :
        ~i_perf_event[g];

      property p_pin_pulse;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        !pin_n_ff[g] && pin_select[g] |=> pin_n_ff[g];
      endproperty
      a_pin_pulse: assert property (p_pin_pulse)
        else $error("breakpoint pin held longer than one cycle");
    end
  endgenerate

  // Pins are outputs only; reporting never feeds back into execution
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      pin_n_ff <= LBR_PIN_IDLE;
    end else begin
      pin_n_ff <= nxt_pin_n;
    end
  end

  // Trace messages; records keep updating but hold no guarantee then
  wire logic msg_fire = msg_enable & (i_branch_taken | i_exc_taken);
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      msg_valid_ff <= 1'b0;
      msg_src_ff   <= LBR_REC_RST;
      msg_tgt_ff   <= LBR_REC_RST;
    end else begin
      msg_valid_ff <= msg_fire;
      if (msg_fire) begin
        msg_src_ff <= i_exc_taken ? i_exc_src : i_branch_src;
        msg_tgt_ff <= i_exc_taken ? i_exc_tgt : i_branch_tgt;
      end
    end
  end

  // Step trap: taken branches only when branch stepping is on
  assign o_step_trap = i_single_step_flag &
    (step_branches ? i_branch_taken : i_insn_retire);

  // Outputs
  assign o_reg_rdata        = rdata_ff;
  assign o_reg_ack          = ack_ff;
  assign o_reg_fault        = fault_ff;
  assign o_breakpoint_pin_n = pin_n_ff;
  assign o_msg_valid        = msg_valid_ff;
  assign o_msg_src          = msg_src_ff;
  assign o_msg_tgt          = msg_tgt_ff;
  assign o_record_enable    = record_enable;
  assign o_step_on_branches = step_branches;

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_records_stable;
    $stable(br_src_ff) && $stable(br_tgt_ff) &&
    $stable(ex_src_ff) && $stable(ex_tgt_ff);
  endsequence

  sequence s_exc_seen;
    rec_exc;
  endsequence

  property p_dbg_clears;
    i_debug_exception |=> !o_record_enable;
  endproperty
  a_dbg_clears: assert property (p_dbg_clears)
    else $error("record enable survived a debug exception");

  property p_dbg_untouched;
    i_debug_exception |=> s_records_stable;
  endproperty
  a_dbg_untouched: assert property (p_dbg_untouched)
    else $error("records changed on a debug exception");

  property p_idle_hold;
    !record_enable |=> s_records_stable;
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("records changed while recording disabled");

  property p_branch_load;
    rec_br |=> br_src_ff == $past(i_branch_src) &&
               br_tgt_ff == $past(i_branch_tgt) &&
               $stable(ex_src_ff);
  endproperty
  a_branch_load: assert property (p_branch_load)
    else $error("taken branch not captured");

  property p_exc_shift;
    s_exc_seen |=> ex_src_ff == $past(br_src_ff) &&
                   ex_tgt_ff == $past(br_tgt_ff) &&
                   br_src_ff == $past(i_exc_src) &&
                   br_tgt_ff == $past(i_exc_tgt);
  endproperty
  a_exc_shift: assert property (p_exc_shift)
    else $error("exception capture order wrong");

  property p_priv_refuse;
    wr_fault && !ctrl_wr |=> $past(ctrl_ff[LBR_CTRL_W-1:1]) ==
                             ctrl_ff[LBR_CTRL_W-1:1] && o_reg_fault;
  endproperty
  a_priv_refuse: assert property (p_priv_refuse)
    else $error("unprivileged control write took effect");

  property p_reset_clear;
    disable iff (1'b0) !i_reset_n |=> ctrl_ff == LBR_CTRL_RST;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("control not clear after reset");

  property p_step_mode;
    i_single_step_flag && step_branches && !i_branch_taken
      |-> !o_step_trap;
  endproperty
  a_step_mode: assert property (p_step_mode)
    else $error("step trap outside a taken branch");

  property p_msg_emit;
    msg_enable && i_branch_taken |=> o_msg_valid;
  endproperty
  a_msg_emit: assert property (p_msg_emit)
    else $error("trace message missing");

  property p_read_back;
    i_reg_rd && i_reg_idx == LBR_IDX_EX_SRC |=>
      o_reg_ack && o_reg_rdata == $past(ex_src_ff);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("record read returned wrong value");

endmodule : lbr_recorder

// >>> rtl/lbr_pkg.sv
// Package for the last branch recorder: register indices, control
// field positions, widths and reset values.
// Assumes one core clock and a synchronous active-low core reset.
package lbr_pkg;

  // Register index carried by the privileged read and write instructions
  localparam int         LBR_IDX_W      = 3;
  localparam logic [2:0] LBR_IDX_CTRL   = 3'h0;
  localparam logic [2:0] LBR_IDX_BR_SRC = 3'h1;
  localparam logic [2:0] LBR_IDX_BR_TGT = 3'h2;
  localparam logic [2:0] LBR_IDX_EX_SRC = 3'h3;
  localparam logic [2:0] LBR_IDX_EX_TGT = 3'h4;

  // Data and record widths, breakpoint pin count
  localparam int LBR_DATA_W = 32;
  localparam int LBR_PINS   = 4;

  // Control field positions
  localparam int LBR_CTRL_W     = 7;
  localparam int LBR_BIT_REC    = 0;
  localparam int LBR_BIT_STEP   = 1;
  localparam int LBR_BIT_PIN_LO = 2;
  localparam int LBR_BIT_PIN_HI = 5;
  localparam int LBR_BIT_MSG    = 6;

  // Privilege level allowed to write control
  localparam logic [1:0] LBR_PRIV_TOP = 2'h0;

  // Reset values
  localparam logic [LBR_CTRL_W-1:0] LBR_CTRL_RST = 7'h00;
  localparam logic [LBR_DATA_W-1:0] LBR_REC_RST  = 32'h0000_0000;
  localparam logic [LBR_PINS-1:0]   LBR_PIN_IDLE = 4'hf;

endpackage : lbr_pkg

// >>> verif/lbr_recorder_tb.sv
// Self-checking bench for the last branch recorder: control access,
// recording, debug exception, stepping, pins and trace messages.
// Assumes one-cycle ack and registered record, pin and message outputs.
`timescale 1ns/100ps

module lbr_recorder_tb import lbr_pkg::*;;
  logic        i_sys_clk, i_reset_n, i_reg_wr, i_reg_rd, i_real_mode;
  logic        i_branch_taken, i_exc_taken, i_debug_exception;
  logic        i_single_step_flag, i_insn_retire, o_reg_ack, o_reg_fault;
  logic        o_step_trap, o_msg_valid, o_record_enable, o_step_on_branches;
  logic [2:0]  i_reg_idx;
  logic [1:0]  i_priv_level;
  logic [31:0] i_reg_wdata, o_reg_rdata, o_msg_src, o_msg_tgt;
  logic [31:0] i_branch_src, i_branch_tgt, i_exc_src, i_exc_tgt;
  logic [3:0]  i_bp_match, i_perf_event, o_breakpoint_pin_n;
  int          errors, total_checks;

  lbr_recorder lbr_recorder_i (.i_sys_clk, .i_reset_n, .i_reg_wr,
    .i_reg_rd, .i_reg_idx, .i_reg_wdata, .i_priv_level, .i_real_mode,
    .o_reg_rdata, .o_reg_ack, .o_reg_fault, .i_branch_taken, .i_branch_src,
    .i_branch_tgt, .i_exc_taken, .i_exc_src, .i_exc_tgt,
    .i_debug_exception, .i_single_step_flag, .i_insn_retire, .o_step_trap,
    .i_bp_match, .i_perf_event, .o_breakpoint_pin_n, .o_msg_valid,
    .o_msg_src, .o_msg_tgt, .o_record_enable, .o_step_on_branches);

  // 250 MHz core clock
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  // Inputs move 1 ns after the edge, clear of the sampling instant
  task automatic tick;
    @(posedge i_sys_clk);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [2:0] idx, input logic [31:0] d,
                        input logic flt);
    i_reg_wr = 1'b1; i_reg_idx = idx; i_reg_wdata = d;
    tick;
    chk("write ack", 32'h1, o_reg_ack);
    chk("write fault", {31'h0, flt}, o_reg_fault);
    i_reg_wr = 1'b0;
    tick;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] idx, input logic [31:0] exp);
    i_reg_rd = 1'b1; i_reg_idx = idx;
    tick;
    chk("read ack", 32'h1, o_reg_ack);
    chk("read data", exp, o_reg_rdata);
    i_reg_rd = 1'b0;
    tick;
  endtask : rd_reg

  // Reads all four records in index order
  task automatic recs(input logic [31:0] bs, bt, es, et);
    rd_reg(LBR_IDX_BR_SRC, bs);
    rd_reg(LBR_IDX_BR_TGT, bt);
    rd_reg(LBR_IDX_EX_SRC, es);
    rd_reg(LBR_IDX_EX_TGT, et);
  endtask : recs

  task automatic ev(input logic b, e, dbg, input logic [31:0] s, t);
    i_branch_taken = b; i_exc_taken = e; i_debug_exception = dbg;
    i_branch_src = s; i_branch_tgt = t + 32'h1;
    i_exc_src = s + 32'h100; i_exc_tgt = t + 32'h101;
    tick;
    i_branch_taken = 1'b0; i_exc_taken = 1'b0; i_debug_exception = 1'b0;
    tick;
  endtask : ev

  task automatic t_access;
    rd_reg(LBR_IDX_CTRL, 32'h0);
    recs(32'h0, 32'h0, 32'h0, 32'h0);
    chk("pins idle", 32'hf, o_breakpoint_pin_n);
    i_priv_level = 2'h3;
    wr_reg(LBR_IDX_CTRL, 32'h1, 1'b1);
    rd_reg(LBR_IDX_CTRL, 32'h0);
    i_real_mode = 1'b1;
    wr_reg(LBR_IDX_CTRL, 32'hffff_ff41, 1'b0);
    rd_reg(LBR_IDX_CTRL, 32'h41);
    i_real_mode = 1'b0; i_priv_level = 2'h0;
    wr_reg(LBR_IDX_CTRL, 32'h0, 1'b0);
    wr_reg(LBR_IDX_BR_SRC, 32'h5a5a, 1'b0);
    rd_reg(LBR_IDX_BR_SRC, 32'h0);
    rd_reg(3'h7, 32'h0);
    $display("test access done");
  endtask : t_access

  task automatic t_record;
    wr_reg(LBR_IDX_CTRL, 32'h1, 1'b0);
    ev(1'b1, 1'b0, 1'b0, 32'ha0, 32'ha4);
    recs(32'ha0, 32'ha5, 32'h0, 32'h0);
    ev(1'b1, 1'b0, 1'b0, 32'hc0, 32'hc4);
    ev(1'b1, 1'b1, 1'b0, 32'hd0, 32'hd4);
    recs(32'h1d0, 32'h1d5, 32'hc0, 32'hc5);
    ev(1'b1, 1'b0, 1'b0, 32'he0, 32'he4);
    chk("record enable", 32'h1, o_record_enable);
    ev(1'b1, 1'b1, 1'b1, 32'hf0, 32'hf4);
    chk("record enable", 32'h0, o_record_enable);
    recs(32'he0, 32'he5, 32'hc0, 32'hc5);
    ev(1'b1, 1'b0, 1'b0, 32'h70, 32'h74);
    recs(32'he0, 32'he5, 32'hc0, 32'hc5);
    wr_reg(LBR_IDX_CTRL, 32'h1, 1'b0);
    ev(1'b1, 1'b0, 1'b0, 32'h80, 32'h84);
    recs(32'h80, 32'h85, 32'hc0, 32'hc5);
    $display("test record done");
  endtask : t_record

  task automatic t_step;
    wr_reg(LBR_IDX_CTRL, 32'h0, 1'b0);
    i_single_step_flag = 1'b1; i_insn_retire = 1'b1;
    #1 chk("step on insn", 32'h1, o_step_trap);
    wr_reg(LBR_IDX_CTRL, 32'h2, 1'b0);
    chk("step on branches", 32'h1, o_step_on_branches);
    chk("no insn step", 32'h0, o_step_trap);
    i_branch_taken = 1'b1;
    #1 chk("branch step", 32'h1, o_step_trap);
    tick;
    i_branch_taken = 1'b0; i_insn_retire = 1'b0; i_single_step_flag = 1'b0;
    $display("test step done");
  endtask : t_step

  task automatic t_pins;
    wr_reg(LBR_IDX_CTRL, 32'h3c, 1'b0);
    i_bp_match = 4'hf;
    tick;
    chk("pins low", 32'h0, o_breakpoint_pin_n);
    tick;
    chk("pins released", 32'hf, o_breakpoint_pin_n);
    wr_reg(LBR_IDX_CTRL, 32'h08, 1'b0);
    i_bp_match = 4'h2; i_perf_event = 4'h5;
    tick;
    chk("pins mixed", 32'h8, o_breakpoint_pin_n);
    i_bp_match = 4'h0; i_perf_event = 4'h0;
    $display("test pins done");
  endtask : t_pins

  task automatic t_msg;
    wr_reg(LBR_IDX_CTRL, 32'h40, 1'b0);
    i_branch_taken = 1'b1; i_branch_src = 32'h300; i_branch_tgt = 32'h401;
    tick;
    chk("msg valid", 32'h1, o_msg_valid);
    chk("msg src", 32'h300, o_msg_src);
    chk("msg tgt", 32'h401, o_msg_tgt);
    i_exc_taken = 1'b1; i_exc_src = 32'h600; i_exc_tgt = 32'h701;
    i_branch_src = 32'h500;
    tick;
    chk("msg exc valid", 32'h1, o_msg_valid);
    chk("msg exc src", 32'h600, o_msg_src);
    chk("msg exc tgt", 32'h701, o_msg_tgt);
    i_branch_taken = 1'b0; i_exc_taken = 1'b0;
    tick;
    chk("msg done", 32'h0, o_msg_valid);
    $display("test msg done");
  endtask : t_msg

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // Watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #20000;
    errors++;
    $display("watchdog expired");
    end_sim;
  end

  initial begin
    {i_reset_n, i_reg_wr, i_reg_rd, i_real_mode, i_branch_taken} = '0;
    {i_exc_taken, i_debug_exception, i_single_step_flag} = '0;
    {i_insn_retire, i_reg_idx, i_priv_level, i_reg_wdata} = '0;
    {i_branch_src, i_branch_tgt, i_exc_src, i_exc_tgt} = '0;
    {i_bp_match, i_perf_event} = '0;
    errors = 0; total_checks = 0;
    repeat (4) @(posedge i_sys_clk);
    #1 i_reset_n = 1'b1;
    t_access;
    t_record;
    t_step;
    t_pins;
    t_msg;
    end_sim;
  end
endmodule : lbr_recorder_tb
